/* File: shared/edcsd_pkg.sv */
package edcsd_pkg;

   // Word and lane geometry
   localparam int          DATA_W          = 32;
   localparam int          LANE_W          = 8;
   localparam int          LANES           = 4;
   localparam int          CHECK_W         = 8;

   // APB register map (byte addresses)
   localparam logic [11:0] CTRL_OFFSET     = 12'h000;
   localparam logic [11:0] STATUS_OFFSET   = 12'h004;

   // CTRL fields
   localparam int          CTRL_MODE_LSB   = 0;
   localparam int          CTRL_MODE_W     = 3;
   localparam int          CTRL_ODD_BIT    = 3;
   localparam int          CTRL_BIDIR_BIT  = 4;
   localparam logic [2:0]  MODE_RESET      = 3'h0;
   localparam logic        ODD_RESET       = 1'b0;
   localparam logic        BIDIR_RESET     = 1'b0;

   // Correction is enabled when the two low mode bits match x11
   localparam logic [1:0]  MODE_CORRECT    = 2'h3;

   // STATUS fields
   localparam int          STAT_CNT_LSB    = 0;
   localparam int          STAT_SD_OE_LSB  = 4;
   localparam int          STAT_MD_OE_BIT  = 8;
   localparam int          STAT_CORR_BIT   = 9;
   localparam int          STAT_CB_LSB     = 16;
   localparam int          STAT_OVF_BIT    = 24;

   // Buffer geometry
   localparam int          BUF_DEPTH       = 2;
   localparam int          BUF_CNT_W       = 2;

endpackage

/* File: rtl/edcsd_two_entry_buf.sv */
`timescale 1ns/1ps
module edcsd_two_entry_buf #(
   parameter int WIDTH = 32
) (
   input  wire logic                           clock,
   input  wire logic                           rst_b,
   input  wire logic                           in_valid,
   output logic                                in_ready,
   input  wire logic [WIDTH-1:0]               in_data,
   output logic                                out_valid,
   input  wire logic                           out_ready,
   output logic [WIDTH-1:0]                    out_data,
   output logic [edcsd_pkg::BUF_CNT_W-1:0]     count
);

   logic [WIDTH-1:0]                 head_ff;
   logic [WIDTH-1:0]                 tail_ff;
   logic [edcsd_pkg::BUF_CNT_W-1:0]  cnt_ff;
   logic                             push;
   logic                             pop;

   assign in_ready  = (cnt_ff != 2'(edcsd_pkg::BUF_DEPTH)) || out_ready;
   assign out_valid = (cnt_ff != 2'h0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = head_ff;
   assign count     = cnt_ff;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
      end
   end

   // Head always holds the oldest word so out_data is a flop
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         head_ff <= '0;
         tail_ff <= '0;
      end else begin
         if (pop) begin
            if (cnt_ff == 2'h2) begin
               head_ff <= tail_ff;
            end else begin
               head_ff <= in_data;
            end
            if (push && cnt_ff == 2'h2) begin
               tail_ff <= in_data;
            end
         end else if (push) begin
            if (cnt_ff == 2'h0) begin
               head_ff <= in_data;
            end else begin
               tail_ff <= in_data;
            end
         end
      end
   end

endmodule

/* File: rtl/edcsd_datapath.sv */
`timescale 1ns/1ps
// Summary of operation
// - Correct memory data only when mode x11
// - Separate buses: unmodified bytes driven for rewrite
// - Separate buses: low-select lanes take system bytes
// - Bidirectional: high-select bytes return to memory pins
// - Low-select lanes steer system byte to memory
// - System latch passes when open, holds otherwise
// - Pipeline latch passes when hold low
// - Pipeline latch feeds system and merge outputs
// - System drivers on only for selected lanes
// - Select n governs bits 8n to 8n+7
// - Memory latch captures data and checkbits
// - Memory drivers on only while enable low
// - Parity even when CTRL odd bit low, else odd
module edcsd_datapath #(
   parameter int DATA_W  = edcsd_pkg::DATA_W,
   parameter int LANES   = edcsd_pkg::LANES,
   parameter int CHECK_W = edcsd_pkg::CHECK_W
) (
   input  wire logic                 CLOCK,
   input  wire logic                 RST_B,
   // APB slave
   input  wire logic                 PSEL,
   input  wire logic                 PENABLE,
   input  wire logic                 PWRITE,
   input  wire logic [11:0]          PADDR,
   input  wire logic [31:0]          PWDATA,
   output logic [31:0]               PRDATA,
   output logic                      PREADY,
   output logic                      PSLVERR,
   // System side
   input  wire logic [DATA_W-1:0]    SYSTEM_DATA_BUS_I,
   output logic [DATA_W-1:0]         SYSTEM_DATA_BUS_O,
   output logic [DATA_W-1:0]         SYSTEM_DATA_BUS_OE,
   input  wire logic [LANES-1:0]     BYTE_LANE_SELECT,
   input  wire logic                 SYSTEM_DRIVE_ENABLE_N,
   input  wire logic                 SYSTEM_LATCH_OPEN,
   input  wire logic                 PIPELINE_LATCH_HOLD,
   output logic [LANES-1:0]          BYTE_PARITY_PINS_O,
   output logic [LANES-1:0]          BYTE_PARITY_PINS_OE,
   // Memory side
   input  wire logic [DATA_W-1:0]    MEMORY_DATA_BUS_I,
   output logic [DATA_W-1:0]         MEMORY_DATA_BUS_O,
   output logic [DATA_W-1:0]         MEMORY_DATA_BUS_OE,
   input  wire logic                 MEMORY_LATCH_OPEN,
   input  wire logic                 MEMORY_DRIVE_ENABLE_N,
   input  wire logic [CHECK_W-1:0]   CHECKBIT_IN,
   // Syndrome logic hookup
   input  wire logic [DATA_W-1:0]    CORRECTION_VECTOR,
   output logic [CHECK_W-1:0]        LATCHED_CHECKBITS,
   output logic [DATA_W-1:0]         MERGED_WORD,
   output logic                      MEMORY_WORD_READY
);

   localparam int LW = edcsd_pkg::LANE_W;

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   logic [2:0]                       mode_ff;
   logic                             odd_parity_ff;
   logic                             bidir_ff;
   logic                             overflow_ff;
   logic [31:0]                      prdata_ff;
   logic                             pslverr_ff;

   logic                             apb_setup;
   logic                             apb_access;
   logic                             addr_ctrl;
   logic                             addr_status;
   logic                             addr_hit;
   logic [31:0]                      ctrl_view;
   logic [31:0]                      status_view;
   logic [31:0]                      nxt_prdata;

   // ------------------------------------------------------------------
   // Latches and data path
   // ------------------------------------------------------------------
   logic [DATA_W-1:0]                sys_hold_ff;
   logic [DATA_W-1:0]                sys_latched;
   logic [DATA_W-1:0]                mem_hold_ff;
   logic [CHECK_W-1:0]               cb_hold_ff;
   logic [DATA_W-1:0]                mem_latched;
   logic [DATA_W-1:0]                corrected_word;
   logic                             correct_en;
   logic [DATA_W-1:0]                pipe_hold_ff;
   logic [DATA_W-1:0]                pipe_source;
   logic [DATA_W-1:0]                pipe_latched;
   logic                             mem_open_d_ff;
   logic                             pipe_hold_d_ff;
   logic                             mem_close_evt;
   logic                             pipe_close_evt;

   logic                             buf_in_ready;
   logic                             buf_out_valid;
   logic [DATA_W-1:0]                buf_out_data;
   logic [edcsd_pkg::BUF_CNT_W-1:0]  buf_count;

   logic [LANES-1:0]                 sd_lane_drive;
   logic                             md_drive;
   logic [DATA_W-1:0]                merged;
   logic [LANES-1:0]                 parity;

   // ------------------------------------------------------------------
   // APB decode; zero wait states, read data staged in setup cycle
   // ------------------------------------------------------------------
   assign apb_setup   = PSEL && !PENABLE;
   assign apb_access  = PSEL && PENABLE;
   assign addr_ctrl   = (PADDR == edcsd_pkg::CTRL_OFFSET);
   assign addr_status = (PADDR == edcsd_pkg::STATUS_OFFSET);
   assign addr_hit    = addr_ctrl || addr_status;

   always_comb begin
      ctrl_view = '0;
      ctrl_view[edcsd_pkg::CTRL_MODE_LSB +: edcsd_pkg::CTRL_MODE_W] = mode_ff;
      ctrl_view[edcsd_pkg::CTRL_ODD_BIT]                            = odd_parity_ff;
      ctrl_view[edcsd_pkg::CTRL_BIDIR_BIT]                          = bidir_ff;
   end

   always_comb begin
      status_view = '0;
      status_view[edcsd_pkg::STAT_CNT_LSB +: edcsd_pkg::BUF_CNT_W] = buf_count;
      status_view[edcsd_pkg::STAT_SD_OE_LSB +: 4]                  = 4'(sd_lane_drive);
      status_view[edcsd_pkg::STAT_MD_OE_BIT]                       = md_drive;
      status_view[edcsd_pkg::STAT_CORR_BIT]                        = correct_en;
      status_view[edcsd_pkg::STAT_CB_LSB +: 8]                     = 8'(cb_hold_ff);
      status_view[edcsd_pkg::STAT_OVF_BIT]                         = overflow_ff;
   end

   always_comb begin
      if (addr_ctrl) begin
         nxt_prdata = ctrl_view;
      end else if (addr_status) begin
         nxt_prdata = status_view;
      end else begin
         nxt_prdata = 32'h0000_0000;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (apb_setup) begin
         prdata_ff  <= PWRITE ? 32'h0000_0000 : nxt_prdata;
         pslverr_ff <= !addr_hit;
      end
   end

   assign PRDATA  = prdata_ff;
   assign PREADY  = 1'b1;
   assign PSLVERR = apb_access && pslverr_ff;

   // CTRL write takes effect at the access edge
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         mode_ff       <= edcsd_pkg::MODE_RESET;
         odd_parity_ff <= edcsd_pkg::ODD_RESET;
         bidir_ff      <= edcsd_pkg::BIDIR_RESET;
      end else if (apb_access && PWRITE && addr_ctrl) begin
         mode_ff       <= PWDATA[edcsd_pkg::CTRL_MODE_LSB +: edcsd_pkg::CTRL_MODE_W];
         odd_parity_ff <= PWDATA[edcsd_pkg::CTRL_ODD_BIT];
         bidir_ff      <= PWDATA[edcsd_pkg::CTRL_BIDIR_BIT];
      end
   end

   // ------------------------------------------------------------------
   // System input latch: open high, hold low
   // ------------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sys_hold_ff <= '0;
      end else if (SYSTEM_LATCH_OPEN) begin
         sys_hold_ff <= SYSTEM_DATA_BUS_I;
      end
   end

   // Mux keeps the latch transparent within the cycle, not one edge late
   assign sys_latched = SYSTEM_LATCH_OPEN ? SYSTEM_DATA_BUS_I : sys_hold_ff;

   // ------------------------------------------------------------------
   // Memory input latch: data and checkbits together
   // ------------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         mem_hold_ff <= '0;
         cb_hold_ff  <= '0;
      end else if (MEMORY_LATCH_OPEN) begin
         mem_hold_ff <= MEMORY_DATA_BUS_I;
         cb_hold_ff  <= CHECKBIT_IN;
      end
   end

   assign mem_latched       = MEMORY_LATCH_OPEN ? MEMORY_DATA_BUS_I : mem_hold_ff;
   assign LATCHED_CHECKBITS = MEMORY_LATCH_OPEN ? CHECKBIT_IN : cb_hold_ff;

   // Upper mode bit is a don't-care for the correct decision
   assign correct_en     = (mode_ff[1:0] == edcsd_pkg::MODE_CORRECT);
   assign corrected_word = correct_en ? (mem_latched ^ CORRECTION_VECTOR) : mem_latched;

   // ------------------------------------------------------------------
   // Word buffer between memory latch and pipeline latch.
   // A word is pushed when the memory latch closes and popped when the
   // pipeline latch closes; up to 2 words wait for a slow pipeline stage, and a word arriving while both are full is dropped unless one pops in that cycle.
   // ------------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         mem_open_d_ff  <= 1'b0;
         pipe_hold_d_ff <= 1'b0;
      end else begin
         mem_open_d_ff  <= MEMORY_LATCH_OPEN;
         pipe_hold_d_ff <= PIPELINE_LATCH_HOLD;
      end
   end

   assign mem_close_evt  = mem_open_d_ff && !MEMORY_LATCH_OPEN;
   assign pipe_close_evt = !pipe_hold_d_ff && PIPELINE_LATCH_HOLD;

   edcsd_two_entry_buf #(
      .WIDTH (DATA_W)
   ) u_word_buf (
      .clock     (CLOCK),
      .rst_b     (RST_B),
      .in_valid  (mem_close_evt),
      .in_ready  (buf_in_ready),
      .in_data   (corrected_word),
      .out_valid (buf_out_valid),
      .out_ready (pipe_close_evt),
      .out_data  (buf_out_data),
      .count     (buf_count)
   );

   // Controller must not close the memory latch again while this is low
   assign MEMORY_WORD_READY = buf_in_ready;

   // Sticky flag: a closing edge that found the buffer full with no pop in that cycle
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         overflow_ff <= 1'b0;
      end else if (mem_close_evt && !buf_in_ready) begin
         overflow_ff <= 1'b1;
      end else if (apb_access && PWRITE && addr_status && PWDATA[edcsd_pkg::STAT_OVF_BIT]) begin
         overflow_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Pipeline latch: transparent while hold is low
   // ------------------------------------------------------------------
   // Empty buffer means flow-through: the live corrected word is seen
   assign pipe_source = buf_out_valid ? buf_out_data : corrected_word;

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pipe_hold_ff <= '0;
      end else if (!PIPELINE_LATCH_HOLD) begin
         pipe_hold_ff <= pipe_source;
      end
   end

   // Hold low all the time passes pipe_source through, but the buffer never pops, so a pushed word stays at the output
   assign pipe_latched = PIPELINE_LATCH_HOLD ? pipe_hold_ff : pipe_source;

   // ------------------------------------------------------------------
   // Per-lane steering, drive enables and parity
   // ------------------------------------------------------------------
   assign md_drive = !MEMORY_DRIVE_ENABLE_N;

   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         // Lane g covers bits 8g .. 8g+7
         assign sd_lane_drive[g] = !SYSTEM_DRIVE_ENABLE_N && BYTE_LANE_SELECT[g];

         // High select: old byte from pipeline; low: new byte from system
         assign merged[g*LW +: LW] = BYTE_LANE_SELECT[g] ? pipe_latched[g*LW +: LW]
                                                          : sys_latched[g*LW +: LW];

         assign SYSTEM_DATA_BUS_O[g*LW +: LW]  = pipe_latched[g*LW +: LW];
         assign SYSTEM_DATA_BUS_OE[g*LW +: LW] = {LW{sd_lane_drive[g]}};

         assign parity[g]              = (^pipe_latched[g*LW +: LW]) ^ odd_parity_ff;
         assign BYTE_PARITY_PINS_O[g]  = parity[g];
         assign BYTE_PARITY_PINS_OE[g] = sd_lane_drive[g];
      end
   endgenerate

   // Checkbit generator always sees the merged word in either configuration
   assign MERGED_WORD = merged;

   // Same merge in either configuration; the config bit is software-visible only
   assign MEMORY_DATA_BUS_O  = merged;
   assign MEMORY_DATA_BUS_OE = {DATA_W{md_drive}};

endmodule

/* File: tb/edcsd_datapath_monitor.sv */
`timescale 1ns/1ps
module edcsd_datapath_monitor #(
   parameter int DATA_W = edcsd_pkg::DATA_W,
   parameter int LANES  = edcsd_pkg::LANES
) (
   input wire logic              CLOCK,
   input wire logic              RST_B,
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [11:0]       PADDR,
   input wire logic [31:0]       PWDATA,
   input wire logic [DATA_W-1:0] SYSTEM_DATA_BUS_I,
   input wire logic [DATA_W-1:0] SYSTEM_DATA_BUS_O,
   input wire logic [DATA_W-1:0] SYSTEM_DATA_BUS_OE,
   input wire logic [LANES-1:0]  BYTE_LANE_SELECT,
   input wire logic              SYSTEM_DRIVE_ENABLE_N,
   input wire logic              SYSTEM_LATCH_OPEN,
   input wire logic              PIPELINE_LATCH_HOLD,
   input wire logic [LANES-1:0]  BYTE_PARITY_PINS_O,
   input wire logic [LANES-1:0]  BYTE_PARITY_PINS_OE,
   input wire logic [DATA_W-1:0] MEMORY_DATA_BUS_O,
   input wire logic [DATA_W-1:0] MEMORY_DATA_BUS_OE,
   input wire logic              MEMORY_DRIVE_ENABLE_N,
   input wire logic [DATA_W-1:0] MERGED_WORD
);
   logic              odd_ff;
   logic [DATA_W-1:0] lane_mask;
   logic [LANES-1:0]  parity_exp;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   always_comb begin
      for (int n = 0; n < LANES; n++) begin
         lane_mask[8*n +: 8] = {8{BYTE_LANE_SELECT[n]}};
         parity_exp[n]       = ^SYSTEM_DATA_BUS_O[8*n +: 8] ^ odd_ff;
      end
   end
   // Parity sense is a register bit, so shadow it from the bus
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         odd_ff <= 1'b0;
      end else if (PSEL && PENABLE && PWRITE && PADDR == edcsd_pkg::CTRL_OFFSET) begin
         odd_ff <= PWDATA[edcsd_pkg::CTRL_ODD_BIT];
      end
   end
   lane_drive_a: assert property (
      SYSTEM_DATA_BUS_OE == (lane_mask & {DATA_W{!SYSTEM_DRIVE_ENABLE_N}})) else $error("lane drive mismatch");
   parity_drive_a: assert property (
      BYTE_PARITY_PINS_OE == (BYTE_LANE_SELECT & {LANES{!SYSTEM_DRIVE_ENABLE_N}})) else $error("parity drive mismatch");
   memory_drive_a: assert property (
      MEMORY_DATA_BUS_OE == {DATA_W{!MEMORY_DRIVE_ENABLE_N}}) else $error("memory drive mismatch");
   parity_value_a: assert property (
      BYTE_PARITY_PINS_O == parity_exp) else $error("byte parity mismatch");
   pipe_hold_a: assert property (
      PIPELINE_LATCH_HOLD && $past(PIPELINE_LATCH_HOLD) |-> $stable(SYSTEM_DATA_BUS_O)) else $error("pipeline moved");
   byte_merge_a: assert property (
      SYSTEM_LATCH_OPEN |-> MERGED_WORD == ((SYSTEM_DATA_BUS_O & lane_mask) | (SYSTEM_DATA_BUS_I & ~lane_mask)))
      else $error("byte merge mismatch");
   memory_word_a: assert property (
      MEMORY_DATA_BUS_O == MERGED_WORD) else $error("memory word mismatch");
   rewrite_lane_a: assert property (
      (MEMORY_DATA_BUS_O & lane_mask) == (SYSTEM_DATA_BUS_O & lane_mask)) else $error("rewrite lane mismatch");
   system_hold_a: assert property (
      !SYSTEM_LATCH_OPEN && $past(!SYSTEM_LATCH_OPEN) && BYTE_LANE_SELECT == 4'h0 && $past(BYTE_LANE_SELECT) == 4'h0
      |-> $stable(MERGED_WORD)) else $error("system latch moved");
endmodule
bind edcsd_datapath edcsd_datapath_monitor #(.DATA_W(DATA_W), .LANES(LANES)) i_monitor (
   .CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
   .PWDATA(PWDATA), .SYSTEM_DATA_BUS_I(SYSTEM_DATA_BUS_I), .SYSTEM_DATA_BUS_O(SYSTEM_DATA_BUS_O),
   .SYSTEM_DATA_BUS_OE(SYSTEM_DATA_BUS_OE), .BYTE_LANE_SELECT(BYTE_LANE_SELECT),
   .SYSTEM_DRIVE_ENABLE_N(SYSTEM_DRIVE_ENABLE_N), .SYSTEM_LATCH_OPEN(SYSTEM_LATCH_OPEN),
   .PIPELINE_LATCH_HOLD(PIPELINE_LATCH_HOLD), .BYTE_PARITY_PINS_O(BYTE_PARITY_PINS_O),
   .BYTE_PARITY_PINS_OE(BYTE_PARITY_PINS_OE), .MEMORY_DATA_BUS_O(MEMORY_DATA_BUS_O),
   .MEMORY_DATA_BUS_OE(MEMORY_DATA_BUS_OE), .MEMORY_DRIVE_ENABLE_N(MEMORY_DRIVE_ENABLE_N),
   .MERGED_WORD(MERGED_WORD));

/* File: tb/edcsd_host_model.sv */
`timescale 1ns/1ps
module edcsd_host_model (
   input  wire logic        clock,
   input  wire logic [31:0] dut_word,
   input  wire logic [31:0] dut_drive,
   input  wire logic [31:0] host_word,
   input  wire logic        host_drive,
   output logic [31:0]      bus_level
);
   logic [31:0] last_ff = 32'h0;
   // Undriven bits flip each cycle so a stale word never passes for data
   always_ff @(posedge clock) begin
      last_ff <= bus_level;
   end
   always_comb begin
      for (int b = 0; b < 32; b++) begin
         if (dut_drive[b]) begin
            bus_level[b] = dut_word[b];
         end else if (host_drive) begin
            bus_level[b] = host_word[b];
         end else begin
            bus_level[b] = ~last_ff[b];
         end
      end
   end
endmodule

/* File: tb/edc_system_side_datapath_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin errors++; $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module edc_system_side_datapath_tb_top;
   logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err_seen;
   logic        sys_drv_n, sys_open, pipe_hold, mem_open, mem_drv_n, host_drive, word_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, exp, sys_i, sys_o, sys_oe, mem_i, mem_o, mem_oe, corr_vec, merged, host_word;
   logic [3:0]  lane_sel, par_o, par_oe;
   logic [7:0]  cb_in, cb_latched;
   int          errors, samples_checked;
   edcsd_host_model i_host (.clock(clock), .dut_word(sys_o), .dut_drive(sys_oe), .host_word(host_word),
      .host_drive(host_drive), .bus_level(sys_i));
   edcsd_datapath i_dut (.CLOCK(clock), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SYSTEM_DATA_BUS_I(sys_i), .SYSTEM_DATA_BUS_O(sys_o), .SYSTEM_DATA_BUS_OE(sys_oe),
      .BYTE_LANE_SELECT(lane_sel), .SYSTEM_DRIVE_ENABLE_N(sys_drv_n), .SYSTEM_LATCH_OPEN(sys_open),
      .PIPELINE_LATCH_HOLD(pipe_hold), .BYTE_PARITY_PINS_O(par_o), .BYTE_PARITY_PINS_OE(par_oe),
      .MEMORY_DATA_BUS_I(mem_i), .MEMORY_DATA_BUS_O(mem_o), .MEMORY_DATA_BUS_OE(mem_oe),
      .MEMORY_LATCH_OPEN(mem_open), .MEMORY_DRIVE_ENABLE_N(mem_drv_n), .CHECKBIT_IN(cb_in),
      .CORRECTION_VECTOR(corr_vec), .LATCHED_CHECKBITS(cb_latched), .MERGED_WORD(merged),
      .MEMORY_WORD_READY(word_ready));
   task automatic print_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int i;
      i = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic push(input logic [31:0] d);
      @(posedge clock);
      mem_open <= 1'b1;
      mem_i <= d;
      @(posedge clock);
      mem_open <= 1'b0;
      mem_i <= ~d;
      @(posedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   initial begin
      errors = 0;
      samples_checked = 0;
      {rst_b, psel, penable, pwrite, paddr, pwdata, lane_sel, sys_open, pipe_hold, mem_i, mem_open} = '0;
      {sys_drv_n, mem_drv_n, host_drive, host_word} = {1'b1, 1'b1, 1'b0, 32'h0};
      cb_in = 8'h5A;
      corr_vec = 32'h0000_0100;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b0, edcsd_pkg::CTRL_OFFSET, 32'h0);
      `CHK("ctrl reset", 32'h0, rd);
      apb(1'b0, edcsd_pkg::STATUS_OFFSET, 32'h0);
      `CHK("status reset", 32'h0, rd);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("unmapped error", 1'b1, err_seen);
      `CHK("unmapped data", 32'h0, rd);
      @(posedge clock);
      mem_open <= 1'b1;
      mem_i <= 32'hA5C3_0F12;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, edcsd_pkg::CTRL_OFFSET, {29'h0, m[2:0]});
         wt(1);
         exp = (m[1:0] == 2'h3) ? 32'hA5C3_0F12 ^ 32'h0000_0100 : 32'hA5C3_0F12;
         `CHK("system word", exp, sys_o);
      end
      apb(1'b0, edcsd_pkg::STATUS_OFFSET, 32'h0);
      `CHK("correct flag", 1'b1, rd[9]);
      for (int k = 0; k < 64; k++) begin
         if (k % 16 == 0) begin
            apb(1'b1, edcsd_pkg::CTRL_OFFSET, {28'h0, k[4], 3'h0});
         end
         @(posedge clock);
         lane_sel <= k[3:0];
         sys_drv_n <= k[5];
         wt(1);
         for (int n = 0; n < 4; n++) begin
            `CHK("lane drive", {8{k[n] & ~k[5]}}, sys_oe[8*n +: 8]);
            `CHK("parity drive", k[n] & ~k[5], par_oe[n]);
            `CHK("byte parity", ^sys_o[8*n +: 8] ^ k[4], par_o[n]);
         end
      end
      @(posedge clock);
      pipe_hold <= 1'b1;
      sys_drv_n <= 1'b1;
      @(posedge clock);
      mem_i <= 32'h1234_5678;
      wt(2);
      `CHK("pipeline hold", 32'hA5C3_0F12, sys_o);
      @(posedge clock);
      pipe_hold <= 1'b0;
      wt(1);
      `CHK("pipeline open", 32'h1234_5678, sys_o);
      apb(1'b1, edcsd_pkg::CTRL_OFFSET, 32'h0000_0010);
      @(posedge clock);
      host_drive <= 1'b1;
      host_word <= 32'hC0DE_F00D;
      sys_open <= 1'b1;
      lane_sel <= 4'h5;
      mem_drv_n <= 1'b0;
      wt(2);
      `CHK("merged word", 32'hC034_F078, mem_o);
      `CHK("memory drive", 32'hFFFF_FFFF, mem_oe);
      apb(1'b0, edcsd_pkg::STATUS_OFFSET, 32'h0);
      `CHK("memory drive flag", 1'b1, rd[8]);
      @(posedge clock);
      sys_open <= 1'b0;
      @(posedge clock);
      host_word <= 32'h0;
      wt(2);
      `CHK("system latch hold", 32'hC034_F078, merged);
      @(posedge clock);
      mem_drv_n <= 1'b1;
      host_drive <= 1'b0;
      wt(1);
      `CHK("memory release", 32'h0, mem_oe);
      `CHK("buffer free", 1'b1, word_ready);
      push(32'h1111_1111);
      push(32'h2222_2222);
      #1;
      `CHK("buffer full", 1'b0, word_ready);
      push(32'h3333_3333);
      cb_in <= 8'hC3;
      apb(1'b0, edcsd_pkg::STATUS_OFFSET, 32'h0);
      `CHK("buffer count", 2'h2, rd[1:0]);
      `CHK("overflow", 1'b1, rd[24]);
      `CHK("held checkbits", 8'h5A, rd[23:16]);
      `CHK("latched checkbits", 8'h5A, cb_latched);
      #1;
      `CHK("buffer head", 32'h1111_1111, sys_o);
      for (int p = 0; p < 2; p++) begin
         @(posedge clock);
         pipe_hold <= 1'b1;
         wt(1);
         `CHK("popped word", p ? 32'h2222_2222 : 32'h1111_1111, sys_o);
         @(posedge clock);
         pipe_hold <= 1'b0;
      end
      wt(1);
      `CHK("live word", 32'h3333_3333, sys_o);
      apb(1'b1, edcsd_pkg::STATUS_OFFSET, 32'h0100_0000);
      apb(1'b0, edcsd_pkg::STATUS_OFFSET, 32'h0);
      `CHK("overflow clear", 1'b0, rd[24]);
      `CHK("buffer empty", 2'h0, rd[1:0]);
      print_verdict();
   end
endmodule
